// ---- hw/eeprom_ctrl_pkg.sv ----
package eeprom_ctrl_pkg;

   // ---------------------------------------------------------------
   // Register byte offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_ADDR_LOW = 8'h00;
   localparam logic [7:0] OFS_ADDR_HIGH = 8'h04;
   localparam logic [7:0] OFS_DATA = 8'h08;
   localparam logic [7:0] OFS_CONTROL = 8'h0C;
   localparam logic [7:0] OFS_INT = 8'h10;
   localparam logic [7:0] OFS_PEEK = 8'h14;

   // ---------------------------------------------------------------
   // Field positions and reset values
   // ---------------------------------------------------------------
   localparam int CTL_TIME_SEL = 7;
   localparam int CTL_ERASE_EN = 6;
   localparam int CTL_ERASE_GO = 5;
   localparam int CTL_MODE = 4;
   localparam int CTL_WRITE_EN = 3;
   localparam int CTL_WRITE_GO = 2;
   localparam int CTL_READ_EN = 1;
   localparam int CTL_READ_GO = 0;
   localparam int INT_ENABLE = 0;
   localparam int INT_GLOBAL = 1;
   localparam int INT_FLAG = 2;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [3:0] OFFSET_LAST = 4'hF;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // ---------------------------------------------------------------
   // Cycle timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 5000;
   localparam int ERASE_SHORT_NS = 3200000;
   localparam int WRITE_SHORT_NS = 2200000;
   localparam int ERASE_LONG_NS = 3700000;
   localparam int WRITE_LONG_NS = 3000000;
   // Worked in 64 bits: nanoseconds times 1000 overflows a 32-bit int
   localparam int ERASE_SHORT_CYC =
      int'((longint'(ERASE_SHORT_NS) * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam int WRITE_SHORT_CYC =
      int'((longint'(WRITE_SHORT_NS) * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam int ERASE_LONG_CYC =
      int'((longint'(ERASE_LONG_NS) * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam int WRITE_LONG_CYC =
      int'((longint'(WRITE_LONG_NS) * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam int TIMER_W = 20;

   typedef enum logic [1:0] {
      OP_NONE = 2'b00,
      OP_PAGE_ERASE = 2'b01,
      OP_BYTE_WRITE = 2'b10,
      OP_PAGE_WRITE = 2'b11
   } op_t;

   typedef struct packed {
      logic awvalid;
      logic [31:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [31:0] araddr;
      logic rready;
   } axi_req_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } axi_rsp_t;

endpackage

// ---- hw/cycle_timer.sv ----
`timescale 1ns/1ps
module cycle_timer (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic start,
   input wire logic [eeprom_ctrl_pkg::TIMER_W-1:0] length,
   output logic done
);

   typedef struct packed {
      logic [eeprom_ctrl_pkg::TIMER_W-1:0] cnt;
      logic done;
   } tmr_t;

   tmr_t q;
   tmr_t d;

   // Done rises exactly length+1 cycles after start and holds until the next start
   always_comb begin
      d = q;
      if (start) begin
         d.cnt = length;
         d.done = 1'b0;
      end else if (q.cnt == eeprom_ctrl_pkg::TIMER_W'(1)) begin
         d.cnt = '0;
         d.done = 1'b1;
      end else if (q.cnt != '0) begin
         d.cnt = q.cnt - eeprom_ctrl_pkg::TIMER_W'(1);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign done = q.done;

endmodule

// ---- hw/done_sync.sv ----
`timescale 1ns/1ps
module done_sync (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic level_in,
   output logic pulse
);

   typedef struct packed {
      logic ff1;
      logic ff2;
      logic ff3;
   } sync_t;

   sync_t q;
   sync_t d;

   always_comb begin
      d.ff1 = level_in;
      d.ff2 = q.ff1;
      d.ff3 = q.ff2;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // Rising edge of the synchronised level, one cycle wide
   assign pulse = q.ff2 & ~q.ff3;

endmodule

// ---- hw/data_eeprom_erase_write_ctrl.sv ----
// Overview of operation
// - Page erase starts only while the operation-mode bit is high; covers the tagged bytes of its 16-byte page.
// - Page buffer cleared at reset and when erase enable falls, not on rise.
// - Page buffer cleared when write enable falls, not when it rises.
// - Upper 5 address bits select the page; hardware never increments them.
// - Page-mode data write tags current address, then offset increments by one.
// - Once offset stopped at the boundary, further page-mode data writes are ignored.
// - Page-mode data write loads the byte into the buffer at offset, increments.
// - Erase starts only if trigger follows the enable-setting write back to back.
// - Write starts only if trigger follows the enable-setting write back to back.
// - Write trigger with write enable low starts nothing.
// - Erase end clears erase trigger, then erase enable.
// - Tagged bytes of an erased page read back as zero.
// - Write end clears write trigger, then write enable.
// - Cycle length measured by an independent timer, fixed delay.
// - Byte mode write programs data at address, erasing the byte first.
// - Write enable resets to zero.
// - Completion flag sets when any erase or write cycle ends.
// - Interrupt request needs local and global enable, stack not full; service clears flag.
// - Time select picks 3.2/2.2 ms or 3.7/3.0 ms erase/write times.
// - Control bits high to low: time, erase en/go, mode, write en/go, read en/go.
// - Address is 9 bits: low byte plus bit 0 of the high register.
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
module data_eeprom_erase_write_ctrl #(
   parameter int unsigned ERASE_SHORT_CYC = eeprom_ctrl_pkg::ERASE_SHORT_CYC,
   parameter int unsigned WRITE_SHORT_CYC = eeprom_ctrl_pkg::WRITE_SHORT_CYC,
   parameter int unsigned ERASE_LONG_CYC = eeprom_ctrl_pkg::ERASE_LONG_CYC,
   parameter int unsigned WRITE_LONG_CYC = eeprom_ctrl_pkg::WRITE_LONG_CYC
) (
   input wire logic aclk,
   input wire logic aresetn,
   input eeprom_ctrl_pkg::axi_req_t s_axi_req,
   output eeprom_ctrl_pkg::axi_rsp_t s_axi_rsp,
   input wire logic stack_full,
   input wire logic irq_ack,
   output logic irq_req
);

   typedef struct packed {
      logic aw_held;
      logic [7:0] aw_addr;
      logic w_held;
      logic [7:0] w_data;
      logic w_lane0;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic [7:0] eeprom_addr_low;
      logic eeprom_addr_high;
      logic [7:0] eeprom_data_reg;
      logic [7:0] eeprom_control_reg;
      logic mem_done_int_enable;
      logic global_int_enable;
      logic mem_done_request_flag;
      logic arm_erase;
      logic arm_write;
      logic stopped;
      logic busy;
      logic finish;
      logic start;
      eeprom_ctrl_pkg::op_t op;
      logic [15:0] tags;
      logic [15:0][7:0] page_buf;
      logic [511:0][7:0] mem;
   } st_t;

   st_t q;
   st_t d;
   logic timer_done;
   logic done_pulse;
   logic [eeprom_ctrl_pkg::TIMER_W-1:0] cycle_len;
   logic [2:0] wsel;
   logic [2:0] rsel;
   logic [7:0] v;
   logic er_go;
   logic wr_go;
   logic [8:0] cur_addr;

   // ---------------------------------------------------------------
   // Register decode
   // ---------------------------------------------------------------
   function automatic logic [2:0] reg_sel(input logic [7:0] a);
      unique case (a)
         eeprom_ctrl_pkg::OFS_ADDR_LOW: reg_sel = 3'h0;
         eeprom_ctrl_pkg::OFS_ADDR_HIGH: reg_sel = 3'h1;
         eeprom_ctrl_pkg::OFS_DATA: reg_sel = 3'h2;
         eeprom_ctrl_pkg::OFS_CONTROL: reg_sel = 3'h3;
         eeprom_ctrl_pkg::OFS_INT: reg_sel = 3'h4;
         eeprom_ctrl_pkg::OFS_PEEK: reg_sel = 3'h5;
         default: reg_sel = 3'h7;
      endcase
   endfunction

   // ---------------------------------------------------------------
   // Cycle timer and completion synchroniser
   // ---------------------------------------------------------------
   always_comb begin
      unique case ({q.op == eeprom_ctrl_pkg::OP_PAGE_ERASE,
                    q.eeprom_control_reg[eeprom_ctrl_pkg::CTL_TIME_SEL]})
         2'b10: cycle_len = eeprom_ctrl_pkg::TIMER_W'(ERASE_SHORT_CYC);
         2'b11: cycle_len = eeprom_ctrl_pkg::TIMER_W'(ERASE_LONG_CYC);
         2'b00: cycle_len = eeprom_ctrl_pkg::TIMER_W'(WRITE_SHORT_CYC);
         2'b01: cycle_len = eeprom_ctrl_pkg::TIMER_W'(WRITE_LONG_CYC);
      endcase
   end

   cycle_timer u_timer (
      .aclk(aclk),
      .aresetn(aresetn),
      .start(q.start),
      .length(cycle_len),
      .done(timer_done)
   );

   done_sync u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .level_in(timer_done),
      .pulse(done_pulse)
   );

   assign cur_addr = {q.eeprom_addr_high, q.eeprom_addr_low};

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      d = q;
      d.start = 1'b0;
      wsel = reg_sel(q.aw_addr);
      rsel = reg_sel(s_axi_req.araddr[7:0]);
      v = q.w_data;
      er_go = 1'b0;
      wr_go = 1'b0;
      if (s_axi_req.awvalid && !q.aw_held && !q.bvalid) begin
         d.aw_held = 1'b1;
         d.aw_addr = s_axi_req.awaddr[7:0];
      end
      if (s_axi_req.wvalid && !q.w_held && !q.bvalid) begin
         d.w_held = 1'b1;
         d.w_data = s_axi_req.wdata[7:0];
         d.w_lane0 = s_axi_req.wstrb[0];
      end
      if (q.bvalid && s_axi_req.bready) begin
         d.bvalid = 1'b0;
      end
      if (q.rvalid && s_axi_req.rready) begin
         d.rvalid = 1'b0;
      end
      if (s_axi_req.arvalid && !q.rvalid) begin
         d.rvalid = 1'b1;
         d.rresp = eeprom_ctrl_pkg::RESP_OKAY;
         d.rdata = '0;
         unique case (rsel)
            3'h0: d.rdata[7:0] = q.eeprom_addr_low;
            3'h1: d.rdata[0] = q.eeprom_addr_high;
            3'h2: d.rdata[7:0] = q.eeprom_data_reg;
            3'h3: d.rdata[7:0] = q.eeprom_control_reg;
            3'h4: d.rdata[2:0] = {q.mem_done_request_flag, q.global_int_enable,
                                  q.mem_done_int_enable};
            3'h5: d.rdata[7:0] = q.mem[cur_addr];
            default: d.rresp = eeprom_ctrl_pkg::RESP_SLVERR;
         endcase
      end
      // Service of the interrupt clears the flag; a completion below still wins
      if (irq_ack) begin
         d.mem_done_request_flag = 1'b0;
      end
      if (q.aw_held && q.w_held) begin
         d.aw_held = 1'b0;
         d.w_held = 1'b0;
         d.bvalid = 1'b1;
         d.bresp = (wsel == 3'h7) ? eeprom_ctrl_pkg::RESP_SLVERR : eeprom_ctrl_pkg::RESP_OKAY;
         // Any write breaks a pending enable/trigger pair
         d.arm_erase = 1'b0;
         d.arm_write = 1'b0;
         if (q.w_lane0 && !q.busy) begin
            unique case (wsel)
               3'h0: begin
                  d.eeprom_addr_low = v;
                  d.stopped = 1'b0;
               end
               3'h1: begin
                  d.eeprom_addr_high = v[0];
                  d.stopped = 1'b0;
               end
               3'h2: begin
                  if (!q.eeprom_control_reg[eeprom_ctrl_pkg::CTL_MODE]) begin
                     d.eeprom_data_reg = v;
                  end else if (!q.stopped) begin
                     d.eeprom_data_reg = v;
                     d.tags[q.eeprom_addr_low[3:0]] = 1'b1;
                     d.page_buf[q.eeprom_addr_low[3:0]] = v;
                     if (q.eeprom_addr_low[3:0] == eeprom_ctrl_pkg::OFFSET_LAST) begin
                        d.stopped = 1'b1;
                     end else begin
                        d.eeprom_addr_low[3:0] = 4'(q.eeprom_addr_low[3:0] + 4'h1);
                     end
                  end
               end
               3'h3: begin
                  er_go = v[eeprom_ctrl_pkg::CTL_ERASE_GO] && v[eeprom_ctrl_pkg::CTL_ERASE_EN]
                     && q.arm_erase && v[eeprom_ctrl_pkg::CTL_MODE];
                  wr_go = v[eeprom_ctrl_pkg::CTL_WRITE_GO] && v[eeprom_ctrl_pkg::CTL_WRITE_EN]
                     && q.arm_write && !er_go;
                  d.eeprom_control_reg = v;
                  d.eeprom_control_reg[eeprom_ctrl_pkg::CTL_READ_GO] = 1'b0;
                  d.eeprom_control_reg[eeprom_ctrl_pkg::CTL_ERASE_GO] = er_go;
                  d.eeprom_control_reg[eeprom_ctrl_pkg::CTL_WRITE_GO] = wr_go;
                  d.arm_erase = v[eeprom_ctrl_pkg::CTL_ERASE_EN]
                     && !q.eeprom_control_reg[eeprom_ctrl_pkg::CTL_ERASE_EN];
                  d.arm_write = v[eeprom_ctrl_pkg::CTL_WRITE_EN]
                     && !q.eeprom_control_reg[eeprom_ctrl_pkg::CTL_WRITE_EN];
                  if (er_go) begin
                     d.busy = 1'b1;
                     d.start = 1'b1;
                     d.op = eeprom_ctrl_pkg::OP_PAGE_ERASE;
                  end else if (wr_go) begin
                     d.busy = 1'b1;
                     d.start = 1'b1;
                     d.op = v[eeprom_ctrl_pkg::CTL_MODE] ? eeprom_ctrl_pkg::OP_PAGE_WRITE
                                                         : eeprom_ctrl_pkg::OP_BYTE_WRITE;
                  end
               end
               3'h4: begin
                  d.mem_done_int_enable = v[eeprom_ctrl_pkg::INT_ENABLE];
                  d.global_int_enable = v[eeprom_ctrl_pkg::INT_GLOBAL];
                  if (v[eeprom_ctrl_pkg::INT_FLAG]) begin
                     d.mem_done_request_flag = 1'b0;
                  end
               end
               default: begin
               end
            endcase
         end
      end
      // Completion: commit to the array, clear trigger now and enable next cycle
      if (done_pulse && q.busy) begin
         unique case (q.op)
            eeprom_ctrl_pkg::OP_PAGE_ERASE: begin
               for (int i = 0; i < 16; i++) begin
                  if (q.tags[i]) begin
                     d.mem[{q.eeprom_addr_high, q.eeprom_addr_low[7:4], 4'(i)}] = 8'h00;
                  end
               end
            end
            eeprom_ctrl_pkg::OP_PAGE_WRITE: begin
               for (int i = 0; i < 16; i++) begin
                  if (q.tags[i]) begin
                     d.mem[{q.eeprom_addr_high, q.eeprom_addr_low[7:4], 4'(i)}] = q.page_buf[i];
                  end
               end
            end
            eeprom_ctrl_pkg::OP_BYTE_WRITE: begin
               d.mem[cur_addr] = q.eeprom_data_reg;
            end
            default: begin
            end
         endcase
         d.eeprom_control_reg[eeprom_ctrl_pkg::CTL_ERASE_GO] = 1'b0;
         d.eeprom_control_reg[eeprom_ctrl_pkg::CTL_WRITE_GO] = 1'b0;
         d.mem_done_request_flag = 1'b1;
         d.finish = 1'b1;
      end
      if (q.finish) begin
         d.eeprom_control_reg[eeprom_ctrl_pkg::CTL_ERASE_EN] = 1'b0;
         d.eeprom_control_reg[eeprom_ctrl_pkg::CTL_WRITE_EN] = 1'b0;
         d.finish = 1'b0;
         d.busy = 1'b0;
         d.op = eeprom_ctrl_pkg::OP_NONE;
      end
      // A falling enable, from software or hardware, empties the page buffer
      if ((q.eeprom_control_reg[eeprom_ctrl_pkg::CTL_ERASE_EN]
           && !d.eeprom_control_reg[eeprom_ctrl_pkg::CTL_ERASE_EN])
          || (q.eeprom_control_reg[eeprom_ctrl_pkg::CTL_WRITE_EN]
           && !d.eeprom_control_reg[eeprom_ctrl_pkg::CTL_WRITE_EN])) begin
         d.tags = '0;
         d.page_buf = '0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign s_axi_rsp.awready = !q.aw_held && !q.bvalid;
   assign s_axi_rsp.wready = !q.w_held && !q.bvalid;
   assign s_axi_rsp.bvalid = q.bvalid;
   assign s_axi_rsp.bresp = q.bresp;
   assign s_axi_rsp.arready = !q.rvalid;
   assign s_axi_rsp.rvalid = q.rvalid;
   assign s_axi_rsp.rdata = q.rdata;
   assign s_axi_rsp.rresp = q.rresp;
   assign irq_req = q.mem_done_int_enable && q.global_int_enable
      && q.mem_done_request_flag && !stack_full;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   logic data_wr;
   assign data_wr = q.aw_held && q.w_held && q.w_lane0 && !q.busy && wsel == 3'h2
      && q.eeprom_control_reg[eeprom_ctrl_pkg::CTL_MODE];

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   erase_needs_mode_a: assert property ($rose(q.busy) && q.op == eeprom_ctrl_pkg::OP_PAGE_ERASE
      |-> q.eeprom_control_reg[eeprom_ctrl_pkg::CTL_MODE])
      else $error("page erase started outside page mode");
   erase_en_fall_a: assert property ($fell(q.eeprom_control_reg[eeprom_ctrl_pkg::CTL_ERASE_EN])
      |-> q.tags == '0)
      else $error("buffer kept after erase enable fell");
   write_en_fall_a: assert property ($fell(q.eeprom_control_reg[eeprom_ctrl_pkg::CTL_WRITE_EN])
      |-> q.tags == '0 && q.page_buf == '0)
      else $error("buffer kept after write enable fell");
   page_bits_hold_a: assert property (data_wr |=> $stable(q.eeprom_addr_low[7:4])
      && $stable(q.eeprom_addr_high))
      else $error("page bits changed by a data write");
   offset_step_a: assert property (data_wr && !q.stopped
      && q.eeprom_addr_low[3:0] != eeprom_ctrl_pkg::OFFSET_LAST
      |=> q.eeprom_addr_low[3:0] == 4'($past(q.eeprom_addr_low[3:0]) + 4'h1)
      && q.tags[$past(q.eeprom_addr_low[3:0])])
      else $error("offset did not step after tagging");
   offset_hold_a: assert property (data_wr
      && q.eeprom_addr_low[3:0] == eeprom_ctrl_pkg::OFFSET_LAST
      |=> q.eeprom_addr_low[3:0] == eeprom_ctrl_pkg::OFFSET_LAST && q.stopped)
      else $error("offset wrapped at page end");
   stopped_ignore_a: assert property (data_wr && q.stopped
      |=> $stable(q.page_buf) && $stable(q.eeprom_data_reg))
      else $error("data write taken after boundary stop");
   no_write_idle_a: assert property (q.aw_held && q.w_held && q.w_lane0 && wsel == 3'h3
      && !q.busy && !q.arm_write && !q.arm_erase |=> !q.busy)
      else $error("cycle started without a valid activation pair");
   sync_delay_a: assert property ($rose(timer_done) |-> ##2 done_pulse)
      else $error("completion not seen two cycles after timer");
   done_order_a: assert property (done_pulse && q.busy
      |=> !q.eeprom_control_reg[eeprom_ctrl_pkg::CTL_ERASE_GO]
      && !q.eeprom_control_reg[eeprom_ctrl_pkg::CTL_WRITE_GO] && q.mem_done_request_flag
      ##1 !q.eeprom_control_reg[eeprom_ctrl_pkg::CTL_ERASE_EN]
      && !q.eeprom_control_reg[eeprom_ctrl_pkg::CTL_WRITE_EN] && !q.busy)
      else $error("trigger and enable not cleared in order");
   irq_gate_a: assert property (irq_req |-> !stack_full && q.global_int_enable)
      else $error("interrupt raised while masked");

   erase_cover_c: cover property ($rose(q.busy) && q.op == eeprom_ctrl_pkg::OP_PAGE_ERASE);
   page_write_c: cover property ($rose(q.busy) && q.op == eeprom_ctrl_pkg::OP_PAGE_WRITE);
   byte_write_c: cover property ($rose(q.busy) && q.op == eeprom_ctrl_pkg::OP_BYTE_WRITE);
   irq_cover_c: cover property (irq_req ##1 irq_ack);

endmodule

// ---- tb/cpu_irq_model.sv ----
`timescale 1ns/1ps
module cpu_irq_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic irq_req,
   input wire logic full_in,
   output logic stack_full,
   output logic irq_ack
);
   // ------------------------------------------------
   // Vector entry, one acknowledge per request
   // ------------------------------------------------
   assign stack_full = full_in;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_ack <= 1'b0;
      end else begin
         irq_ack <= irq_req & ~irq_ack;
      end
   end
endmodule

// ---- tb/tb.sv ----
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
   $display("mismatch %s exp %h got %h", n, e, g); end end
module tb;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic full = 1'b1;
   logic stack_full, irq_ack, irq_req;
   eeprom_ctrl_pkg::axi_req_t req;
   eeprom_ctrl_pkg::axi_rsp_t rsp;
   logic [7:0] d;
   logic [1:0] resp;
   int err_count = 0;
   int samples_checked = 0;
   always #2.5 aclk = ~aclk;
   // ------------------------------------------------
   // Block and interrupt partner
   // ------------------------------------------------
   data_eeprom_erase_write_ctrl #(.ERASE_SHORT_CYC(20), .WRITE_SHORT_CYC(20),
      .ERASE_LONG_CYC(30), .WRITE_LONG_CYC(30)) i_data_eeprom_erase_write_ctrl (
      .aclk(aclk), .aresetn(aresetn), .s_axi_req(req), .s_axi_rsp(rsp),
      .stack_full(stack_full), .irq_ack(irq_ack), .irq_req(irq_req));
   cpu_irq_model i_cpu_irq_model (.aclk(aclk), .aresetn(aresetn), .irq_req(irq_req),
      .full_in(full), .stack_full(stack_full), .irq_ack(irq_ack));
   // Handshakes are judged on settled values at the falling edge, acted on at the rising one
   task wr(input logic [7:0] a, input logic [7:0] v);
      int n;
      logic aw_hit, w_hit, b_hit;
      req.awaddr <= 32'(a);
      req.wdata <= 32'(v);
      req.wstrb <= 4'hF;
      req.awvalid <= 1'b1;
      req.wvalid <= 1'b1;
      n = 0;
      do begin
         @(negedge aclk);
         aw_hit = req.awvalid && rsp.awready;
         w_hit = req.wvalid && rsp.wready;
         b_hit = rsp.bvalid === 1'b1;
         if (b_hit) resp = rsp.bresp;
         @(posedge aclk);
         if (aw_hit) req.awvalid <= 1'b0;
         if (w_hit) req.wvalid <= 1'b0;
         n++;
      end while (!b_hit && n < 50);
      if (!b_hit) err_count++;
   endtask
   task rd(input logic [7:0] a);
      int n;
      logic ar_hit, r_hit;
      req.araddr <= 32'(a);
      req.arvalid <= 1'b1;
      n = 0;
      do begin
         @(negedge aclk);
         ar_hit = req.arvalid && rsp.arready;
         r_hit = rsp.rvalid === 1'b1;
         if (r_hit) begin
            d = rsp.rdata[7:0];
            resp = rsp.rresp;
         end
         @(posedge aclk);
         if (ar_hit) req.arvalid <= 1'b0;
         n++;
      end while (!r_hit && n < 50);
      if (!r_hit) err_count++;
   endtask
   task wctl(input logic [7:0] v);
      wr(eeprom_ctrl_pkg::OFS_CONTROL, v);
   endtask
   task seta(input logic [8:0] a);
      wr(eeprom_ctrl_pkg::OFS_ADDR_HIGH, {7'h00, a[8]});
      wr(eeprom_ctrl_pkg::OFS_ADDR_LOW, a[7:0]);
   endtask
   task peek(input logic [8:0] a, input logic [7:0] e);
      seta(a);
      rd(eeprom_ctrl_pkg::OFS_PEEK);
      `CHK("array", e, d)
   endtask
   task wait_go(input int b);
      int n;
      n = 0;
      do begin
         rd(eeprom_ctrl_pkg::OFS_CONTROL);
         n++;
      end while (d[b] !== 1'b0 && n < 100);
      `CHK("go bit", 1'b0, d[b])
      // Enable clears one cycle after the trigger, so read the control word once more
      rd(eeprom_ctrl_pkg::OFS_CONTROL);
   endtask
   task t_reset;
      rd(eeprom_ctrl_pkg::OFS_CONTROL);
      `CHK("ctrl", 8'h00, d)
      wr(eeprom_ctrl_pkg::OFS_ADDR_HIGH, 8'hFF);
      rd(eeprom_ctrl_pkg::OFS_ADDR_HIGH);
      `CHK("addr high", 8'h01, d)
      rd(8'h18);
      `CHK("resp", eeprom_ctrl_pkg::RESP_SLVERR, resp)
      wr(8'h18, 8'h00);
      `CHK("bresp", eeprom_ctrl_pkg::RESP_SLVERR, resp)
      $display("test reset done");
   endtask
   task t_erase1;
      wctl(8'h10);
      seta(9'h12E);
      wr(eeprom_ctrl_pkg::OFS_DATA, 8'h00);
      wr(eeprom_ctrl_pkg::OFS_DATA, 8'h00);
      wctl(8'h50);
      wctl(8'h70);
      wait_go(5);
      `CHK("ctrl", 8'h10, d)
      $display("test erase done");
   endtask
   task t_pwrite;
      wr(eeprom_ctrl_pkg::OFS_INT, 8'h01);
      seta(9'h12E);
      wr(eeprom_ctrl_pkg::OFS_DATA, 8'hA5);
      wr(eeprom_ctrl_pkg::OFS_DATA, 8'h5A);
      wr(eeprom_ctrl_pkg::OFS_DATA, 8'h33);
      rd(eeprom_ctrl_pkg::OFS_DATA);
      `CHK("data", 8'h5A, d)
      rd(eeprom_ctrl_pkg::OFS_ADDR_LOW);
      `CHK("addr low", 8'h2F, d)
      wctl(8'h18);
      wctl(8'h1C);
      wait_go(2);
      `CHK("ctrl", 8'h10, d)
      rd(eeprom_ctrl_pkg::OFS_INT);
      `CHK("int", 8'h05, d)
      wr(eeprom_ctrl_pkg::OFS_INT, 8'h03);
      `CHK("irq", 1'b0, irq_req)
      full <= 1'b0;
      @(negedge aclk);
      `CHK("irq", 1'b1, irq_req)
      repeat (4) @(posedge aclk);
      rd(eeprom_ctrl_pkg::OFS_INT);
      `CHK("int", 8'h03, d)
      wr(eeprom_ctrl_pkg::OFS_INT, 8'h01);
      peek(9'h12E, 8'hA5);
      peek(9'h12F, 8'h5A);
      peek(9'h130, 8'h00);
      $display("test page write done");
   endtask
   task t_erase2;
      seta(9'h12E);
      wr(eeprom_ctrl_pkg::OFS_DATA, 8'hFF);
      wctl(8'h50);
      wctl(8'h70);
      wait_go(5);
      peek(9'h12E, 8'h00);
      peek(9'h12F, 8'h5A);
      rd(eeprom_ctrl_pkg::OFS_INT);
      `CHK("int", 8'h05, d)
      wr(eeprom_ctrl_pkg::OFS_INT, 8'h05);
      rd(eeprom_ctrl_pkg::OFS_INT);
      `CHK("int", 8'h01, d)
      $display("test tagged erase done");
   endtask
   task t_disarm;
      seta(9'h12F);
      wr(eeprom_ctrl_pkg::OFS_DATA, 8'hFF);
      wctl(8'h50);
      seta(9'h12F);
      wctl(8'h70);
      repeat (60) @(posedge aclk);
      peek(9'h12F, 8'h5A);
      wctl(8'h10);
      wctl(8'h50);
      wctl(8'h70);
      wait_go(5);
      peek(9'h12F, 8'h5A);
      $display("test disarm done");
   endtask
   task t_byte;
      wctl(8'h00);
      seta(9'h005);
      wr(eeprom_ctrl_pkg::OFS_DATA, 8'h3C);
      wctl(8'h04);
      repeat (60) @(posedge aclk);
      peek(9'h005, 8'h00);
      wctl(8'h88);
      wctl(8'h8C);
      wait_go(2);
      peek(9'h005, 8'h3C);
      $display("test byte write done");
   endtask
   task end_sim;
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      #100000;
      err_count++;
      end_sim;
   end
   initial begin
      req = '0;
      req.bready = 1'b1;
      req.rready = 1'b1;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset;
      t_erase1;
      t_pwrite;
      t_erase2;
      t_disarm;
      t_byte;
      end_sim;
   end
endmodule
